/* xspi_host_pkg.sv */
/*
  constants and state encoding shared by the octal ddr psram host.
  assumes one host per device select and a link clock made here by
  dividing the system clock by four.
*/
package xspi_host_pkg;

  // half link cycles per phase (two bytes per link clock cycle)
  localparam logic [16:0] CMD_HALVES = 17'h00002;
  localparam logic [16:0] ADDR_HALVES = 17'h00004;
  localparam int ADDR_W = 32;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  // default latency count and read drain time in system cycles
  localparam int LAT_COUNT_DEF = 6;
  localparam int DRAIN_CYC_DEF = 8;
  // reset values of the link pins
  localparam logic CS_N_RST = 1'b1;
  localparam logic CK_RST = 1'b0;

  // gray coded along idle-cmd-addr-lat-data-drain-end
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_CMD = 3'h1,
    S_ADDR = 3'h3,
    S_LAT = 3'h2,
    S_DATA = 3'h6,
    S_DRAIN = 3'h7,
    S_END = 3'h5
  } state_t;

endpackage

/* xspi_sync2.sv */
/*
  two flip-flop synchroniser for a bus of levels.
  assumes each bit may change at any time relative to clk_i.
*/
`timescale 1ns/100ps
module xspi_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

/* xspi_host.sv */
/*
  host controller for an octal ddr pseudo static ram link: frames one
  transaction per request, makes the link clock, writes and reads words.
  assumes the user supplies a write word whenever wr_take_o pulses and
  that the device starts read data right after the latency period.
*/
`timescale 1ns/100ps
module xspi_host #(
  parameter int LAT_COUNT = xspi_host_pkg::LAT_COUNT_DEF,
  parameter int DRAIN_CYC = xspi_host_pkg::DRAIN_CYC_DEF
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [7:0] req_opcode_i,
  input wire logic req_has_addr_i,
  input wire logic [31:0] req_addr_i,
  input wire logic req_write_i,
  input wire logic req_latency_i,
  input wire logic [15:0] req_words_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [1:0] wr_mask_i,
  output logic wr_take_o,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  output logic busy_o,
  output logic link_cs_n_o,
  output logic link_clock_true_o,
  output logic link_clock_comp_o,
  output logic link_reset_n_o,
  input wire logic [7:0] link_dq_i,
  output logic [7:0] link_dq_o,
  output logic link_dq_oe_o,
  input wire logic strobe_mask_line_i,
  output logic strobe_mask_line_o,
  output logic strobe_mask_line_oe_o
);

  if (LAT_COUNT < 1 || LAT_COUNT > 15) begin : g_lat_chk
    $error("LAT_COUNT must be 1 to 15");
  end
  if (DRAIN_CYC < 4 || DRAIN_CYC > 15) begin : g_drain_chk
    $error("DRAIN_CYC must be 4 to 15");
  end

  // last system cycle of the latency phase for one and two counts
  localparam int LAT_ONE_LAST = 4 * LAT_COUNT - 1;
  localparam int LAT_TWO_LAST = 8 * LAT_COUNT - 1;

  typedef struct packed {
    xspi_host_pkg::state_t st;
    logic ph;
    logic [16:0] half;
    logic ck;
    logic cs_n;
    logic rst_n;
    logic [7:0] dq;
    logic dq_oe;
    logic strobe_mask_line;
    logic strobe_mask_line_oe;
    logic [7:0] op;
    logic [31:0] addr;
    logic wr;
    logic lat_en;
    logic has_addr;
    logic [15:0] words;
    logic lat2;
    logic [7:0] wlo;
    logic mlo;
    logic stb_q;
    logic edge_q;
    logic rhi;
    logic [7:0] rbyte;
    logic [15:0] rdata;
    logic rvalid;
    logic [3:0] drain;
  } host_state_t;

  host_state_t s_q;
  host_state_t s_d;
  logic [7:0] dq_s;
  logic stb_s;
  logic wr_take;
  logic [16:0] lat_halves;
  logic [16:0] data_halves;
  logic [16:0] tgt;

  // both link inputs come from the device's timing, so they are synced
  xspi_sync2 #(.WIDTH(9)) u_sync (
    .clk_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .async_i({strobe_mask_line_i, link_dq_i}),
    .sync_o({stb_s, dq_s})
  );

  // one or two latency counts, each two half cycles
  assign lat_halves = s_q.lat2 ? 17'(LAT_COUNT * 4) : 17'(LAT_COUNT * 2);
  assign data_halves = {s_q.words, 1'b0};

  always_comb begin
    case (s_q.st)
      xspi_host_pkg::S_CMD: tgt = xspi_host_pkg::CMD_HALVES;
      xspi_host_pkg::S_ADDR: tgt = xspi_host_pkg::ADDR_HALVES;
      xspi_host_pkg::S_LAT: tgt = lat_halves;
      xspi_host_pkg::S_DATA: tgt = data_halves;
      default: tgt = 17'h00000;
    endcase
  end

  always_comb begin
    s_d = s_q;
    wr_take = 1'b0;
    s_d.rvalid = 1'b0;
    s_d.rst_n = 1'b1;
    s_d.stb_q = stb_s;
    // read bytes are taken one cycle after a strobe change, mid byte
    s_d.edge_q = !s_q.wr && (stb_s != s_q.stb_q) &&
      (s_q.st == xspi_host_pkg::S_DATA || s_q.st == xspi_host_pkg::S_DRAIN);
    if (s_q.edge_q) begin
      if (!s_q.rhi) begin
        s_d.rbyte = dq_s;
        s_d.rhi = 1'b1;
      end else begin
        s_d.rdata = {s_q.rbyte, dq_s}; // first byte is the low address
        s_d.rhi = 1'b0;
        s_d.rvalid = 1'b1;
      end
    end
    // drive the byte at phase 0, clock edge at phase 1 centres it
    if (s_q.st != xspi_host_pkg::S_IDLE && s_q.st != xspi_host_pkg::S_END &&
        s_q.st != xspi_host_pkg::S_DRAIN) begin
      s_d.ph = !s_q.ph;
      if (!s_q.ph) begin
        case (s_q.st)
          xspi_host_pkg::S_CMD: begin
            s_d.dq = s_q.op; // same opcode on both edges
            s_d.dq_oe = 1'b1;
          end
          xspi_host_pkg::S_ADDR: begin
            s_d.dq = s_q.addr[31 - 8 * s_q.half[1:0] -: 8];
            s_d.dq_oe = 1'b1;
            s_d.lat2 = s_q.lat2 | stb_s;
          end
          xspi_host_pkg::S_LAT: begin
            s_d.dq_oe = 1'b0;
          end
          xspi_host_pkg::S_DATA: begin
            s_d.dq_oe = s_q.wr;
            s_d.strobe_mask_line_oe = s_q.wr;
            if (s_q.wr && !s_q.half[0]) begin
              wr_take = 1'b1;
              s_d.dq = wr_data_i[15:8];
              s_d.wlo = wr_data_i[7:0];
              s_d.strobe_mask_line = wr_mask_i[1]; // high masks the byte
              s_d.mlo = wr_mask_i[0];
            end else if (s_q.wr) begin
              s_d.dq = s_q.wlo;
              s_d.strobe_mask_line = s_q.mlo;
            end
          end
          default: begin
            s_d.dq_oe = 1'b0;
          end
        endcase
      end else begin
        s_d.ck = !s_q.ck;
        s_d.half = s_q.half + 17'h00001;
        if (s_q.half == tgt - 17'h00001) begin
          s_d.half = 17'h00000;
          case (s_q.st)
            xspi_host_pkg::S_CMD: begin
              // address follows or the command stands alone
              s_d.st = s_q.has_addr ? xspi_host_pkg::S_ADDR :
                xspi_host_pkg::S_END;
            end
            xspi_host_pkg::S_ADDR: begin
              // three cycles of command and address, then latency if lat_en is set, else data or end
              if (s_q.lat_en)
                s_d.st = xspi_host_pkg::S_LAT;
              else if (s_q.words != 16'h0000)
                s_d.st = xspi_host_pkg::S_DATA;
              else
                s_d.st = xspi_host_pkg::S_END;
            end
            xspi_host_pkg::S_LAT: begin
              s_d.st = (s_q.words != 16'h0000) ? xspi_host_pkg::S_DATA :
                xspi_host_pkg::S_END;
            end
            default: begin
              s_d.st = s_q.wr ? xspi_host_pkg::S_END :
                xspi_host_pkg::S_DRAIN;
              s_d.drain = 4'(DRAIN_CYC);
            end
          endcase
        end
      end
    end
    case (s_q.st)
      xspi_host_pkg::S_IDLE: begin
        s_d.ck = xspi_host_pkg::CK_RST; // clock parked between frames
        s_d.dq_oe = 1'b0;
        s_d.strobe_mask_line_oe = 1'b0;
        s_d.cs_n = xspi_host_pkg::CS_N_RST;
        if (req_valid_i) begin
          s_d.st = xspi_host_pkg::S_CMD;
          s_d.cs_n = 1'b0; // select falls while the clock is idle
          s_d.ph = 1'b0;
          s_d.half = 17'h00000;
          s_d.op = req_opcode_i;
          s_d.has_addr = req_has_addr_i;
          s_d.addr = req_addr_i;
          s_d.wr = req_write_i;
          s_d.lat_en = req_latency_i;
          s_d.words = req_words_i;
          s_d.lat2 = 1'b0;
          s_d.rhi = 1'b0;
        end
      end
      xspi_host_pkg::S_DRAIN: begin
        // clock stays idle while late synced bytes arrive
        s_d.dq_oe = 1'b0;
        s_d.strobe_mask_line_oe = 1'b0;
        s_d.drain = s_q.drain - 4'h1;
        if (s_q.drain == 4'h1)
          s_d.st = xspi_host_pkg::S_END;
      end
      xspi_host_pkg::S_END: begin
        s_d.cs_n = 1'b1; // clock already low here
        s_d.dq_oe = 1'b0;
        s_d.strobe_mask_line_oe = 1'b0;
        s_d.st = xspi_host_pkg::S_IDLE;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
      s_q.st <= xspi_host_pkg::S_IDLE;
      s_q.cs_n <= xspi_host_pkg::CS_N_RST;
      s_q.ck <= xspi_host_pkg::CK_RST;
      s_q.rst_n <= 1'b0; // device held in reset with the host
    end else begin
      s_q <= s_d;
    end
  end

  assign req_ready_o = (s_q.st == xspi_host_pkg::S_IDLE);
  assign busy_o = (s_q.st != xspi_host_pkg::S_IDLE);
  assign wr_take_o = wr_take;
  assign rd_data_o = s_q.rdata;
  assign rd_valid_o = s_q.rvalid;
  // one select per instance, never shared
  assign link_cs_n_o = s_q.cs_n;
  assign link_clock_true_o = s_q.ck;
  assign link_clock_comp_o = !s_q.ck;
  assign link_reset_n_o = s_q.rst_n;
  assign link_dq_o = s_q.dq;
  assign link_dq_oe_o = s_q.dq_oe;
  assign strobe_mask_line_o = s_q.strobe_mask_line;
  assign strobe_mask_line_oe_o = s_q.strobe_mask_line_oe;

  property p_cs_fall_idle;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    $fell(link_cs_n_o) |-> !link_clock_true_o ##1 !link_clock_true_o;
  endproperty
  a_cs_fall_idle: assert property (p_cs_fall_idle)
    else $error("select fell with clock not idle");

  property p_cs_rise_idle;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(link_cs_n_o) |-> !link_clock_true_o && $past(!link_clock_true_o);
  endproperty
  a_cs_rise_idle: assert property (p_cs_rise_idle)
    else $error("select rose with clock not idle");

  property p_ddr_toggle;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (s_q.st == xspi_host_pkg::S_CMD && !s_q.ph) |=>
      $stable(link_clock_true_o) ##1 $changed(link_clock_true_o);
  endproperty
  a_ddr_toggle: assert property (p_ddr_toggle)
    else $error("link clock not toggling each half cycle");

  property p_cmd_repeat;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(s_q.st == xspi_host_pkg::S_CMD) |=> link_dq_oe_o &&
      link_dq_o == s_q.op ##2 link_dq_o == s_q.op;
  endproperty
  a_cmd_repeat: assert property (p_cmd_repeat)
    else $error("opcode not repeated on both edges");

  property p_addr_msb;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(s_q.st == xspi_host_pkg::S_ADDR) |=>
      link_dq_o == s_q.addr[31:24] ##2 link_dq_o == s_q.addr[23:16];
  endproperty
  a_addr_msb: assert property (p_addr_msb)
    else $error("address not sent msb first");

  property p_idle_clock;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    link_cs_n_o |-> !link_clock_true_o && !link_dq_oe_o;
  endproperty
  a_idle_clock: assert property (p_idle_clock)
    else $error("clock or data driven with select high");

  property p_mask_only_write;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    strobe_mask_line_oe_o |-> s_q.wr && (s_q.st == xspi_host_pkg::S_DATA ||
      $past(s_q.st) == xspi_host_pkg::S_DATA);
  endproperty
  a_mask_only_write: assert property (p_mask_only_write)
    else $error("strobe driven outside write data");

  property p_no_lat_reg_write;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (s_q.st == xspi_host_pkg::S_ADDR && !s_q.lat_en && s_q.words != 16'h0000)
      ##1 (s_q.st != xspi_host_pkg::S_ADDR) |-> s_q.st == xspi_host_pkg::S_DATA;
  endproperty
  a_no_lat_reg_write: assert property (p_no_lat_reg_write)
    else $error("register write entered latency");

  // latency measured in system cycles, independent of the half counter
  property p_lat_len;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(s_q.st == xspi_host_pkg::S_LAT) && !s_q.lat2 |->
      ##LAT_ONE_LAST s_q.st == xspi_host_pkg::S_LAT ##1
      s_q.st != xspi_host_pkg::S_LAT;
  endproperty
  a_lat_len: assert property (p_lat_len)
    else $error("single latency length wrong");

  property p_lat_len_two;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(s_q.st == xspi_host_pkg::S_LAT) && s_q.lat2 |->
      ##LAT_TWO_LAST s_q.st == xspi_host_pkg::S_LAT ##1
      s_q.st != xspi_host_pkg::S_LAT;
  endproperty
  a_lat_len_two: assert property (p_lat_len_two)
    else $error("double latency length wrong");

  property p_word_pair;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    rd_valid_o |-> $past(s_q.edge_q) && !s_q.rhi;
  endproperty
  a_word_pair: assert property (p_word_pair)
    else $error("read word without two bytes");

endmodule

/* psram_dev_model.sv */
/*
  behavioural model of the octal ddr psram device on the far end of the link.
  assumes the host makes the link clock and owns select and reset.
*/
`timescale 1ns/100ps
module psram_dev_model #(
  parameter int LAT = 3,
  parameter logic [7:0] RD_OP = 8'h11,
  parameter logic [7:0] WR_OP = 8'h22,
  parameter logic [7:0] RW_OP = 8'h33
) (
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic ck_i,
  input wire logic refresh_i,
  input wire logic [7:0] dq_i,
  input wire logic st_i,
  output logic [7:0] dq_o,
  output logic st_o
);
  logic [15:0] mem [0:255];
  logic [15:0] cfg_q;
  logic [31:0] addr;
  logic [7:0] op, dq_v, w;
  logic ref_q, drv_dq, drv_st, st_v, cmd_bad;
  int e, k, lat;
  // released lines show the inverse of the last value, never a hold
  assign dq_o = drv_dq ? dq_v : ~dq_v;
  assign st_o = drv_st ? st_v : ~st_v;
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    {cfg_q, cmd_bad, drv_dq, drv_st, st_v, dq_v, addr} = '0;
  end
  always @(negedge cs_n_i) begin
    e = 0;
    ref_q = refresh_i;
    drv_st = rst_n_i; // refresh request during command/address
    st_v = refresh_i;
  end
  always @(posedge cs_n_i or negedge rst_n_i) begin
    drv_dq = 1'b0;
    drv_st = 1'b0;
  end
  // one byte per link clock edge, either direction
  always @(ck_i) begin
    if (!cs_n_i && rst_n_i) begin
      if (e == 0) op = dq_i;
      else if (e == 1 && dq_i !== op) cmd_bad = 1'b1;
      if (e >= 2 && e < 6) addr = {addr[23:0], dq_i};
      if (e == 6) begin
        drv_st = (op == RD_OP); // strobe low until read data
        st_v = 1'b0;
      end
      lat = (op == RW_OP) ? 0 : LAT * (ref_q ? 4 : 2);
      k = e - 6 - lat;
      w = addr[7:0] + 8'(k / 2); // word address, linear
      if (k >= 0 && op == RD_OP) begin
        drv_dq = 1'b1;
        st_v = ~st_v; // data changes with the strobe
        dq_v = k[0] ? mem[w][7:0] : mem[w][15:8];
      end
      if (k >= 0 && op == RW_OP) begin
        if (k[0]) cfg_q[7:0] = dq_i;
        else cfg_q[15:8] = dq_i;
      end
      if (k >= 0 && op == WR_OP && !st_i) begin
        if (k[0]) mem[w][7:0] = dq_i;
        else mem[w][15:8] = dq_i;
      end
      e = e + 1;
    end
  end
endmodule

/* octal_ddr_psram_slave_port_test.sv */
/*
  self-checking bench for the octal ddr psram host controller.
  assumes psram_dev_model stands on the link and keeps a shadow of it.
*/
`timescale 1ns/100ps
module octal_ddr_psram_slave_port_test;
  localparam int LAT = 3;
  localparam logic [7:0] RD_OP = 8'h11;
  localparam logic [7:0] WR_OP = 8'h22;
  localparam logic [7:0] RW_OP = 8'h33;
  logic clk_sys_i, reset_n_i, req_valid_i, req_ready_o, req_has_addr_i;
  logic req_write_i, req_latency_i, wr_take_o, rd_valid_o, busy_o;
  logic link_cs_n_o, link_clock_true_o, link_clock_comp_o, link_reset_n_o;
  logic link_dq_oe_o, strobe_mask_line_o, strobe_mask_line_oe_o, d_st, st_w;
  logic refresh;
  logic [7:0] req_opcode_i, link_dq_o, d_dq, dq_w;
  logic [31:0] req_addr_i;
  logic [15:0] req_words_i, wr_data_i, rd_data_o;
  logic [1:0] wr_mask_i;
  logic [15:0] shadow [0:255];
  logic [15:0] wbuf [0:15];
  logic [1:0] mbuf [0:15];
  logic [31:0] rd_q [$];
  int rise_q [$];
  int n_fail, samples_checked, rises, wi, cyc;
  integer seed = 32'h912d3448;
  assign dq_w = link_dq_oe_o ? link_dq_o : d_dq;
  assign st_w = strobe_mask_line_oe_o ? strobe_mask_line_o : d_st;
  xspi_host #(.LAT_COUNT(LAT), .DRAIN_CYC(8)) dut (
    .clk_sys_i, .reset_n_i, .req_valid_i, .req_ready_o, .req_opcode_i,
    .req_has_addr_i, .req_addr_i, .req_write_i, .req_latency_i,
    .req_words_i, .wr_data_i, .wr_mask_i, .wr_take_o, .rd_data_o,
    .rd_valid_o, .busy_o, .link_cs_n_o, .link_clock_true_o,
    .link_clock_comp_o, .link_reset_n_o, .link_dq_i(dq_w), .link_dq_o,
    .link_dq_oe_o, .strobe_mask_line_i(st_w), .strobe_mask_line_o,
    .strobe_mask_line_oe_o);
  psram_dev_model #(.LAT(LAT), .RD_OP(RD_OP), .WR_OP(WR_OP), .RW_OP(RW_OP))
    dev (.rst_n_i(link_reset_n_o), .cs_n_i(link_cs_n_o),
    .ck_i(link_clock_true_o), .refresh_i(refresh), .dq_i(dq_w),
    .st_i(st_w), .dq_o(d_dq), .st_o(d_st));
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // bench stalls on ready, then waits for busy to fall; the user write side has no back-pressure
  task automatic run(input logic [7:0] op, input logic ha, input logic wr,
      input logic lt, input int nw, input logic [31:0] ad);
    int g;
    logic [7:0] w;
    @(negedge clk_sys_i);
    refresh = 1'($random(seed));
    wi = 0;
    for (int i = 0; i < nw; i++) begin
      w = ad[7:0] + 8'(i);
      if (!wr) rd_q.push_back({16'h0000, shadow[w]});
      wbuf[i] = 16'($random(seed));
      mbuf[i] = 2'($random(seed));
      if (op == WR_OP && !mbuf[i][1]) shadow[w][15:8] = wbuf[i][15:8];
      if (op == WR_OP && !mbuf[i][0]) shadow[w][7:0] = wbuf[i][7:0];
    end
    rise_q.push_back(1 + (ha ? 2 : 0) + (lt ? LAT * (refresh ? 2 : 1) : 0)
      + nw);
    {req_opcode_i, req_has_addr_i, req_write_i} = {op, ha, wr};
    {req_latency_i, req_words_i, req_addr_i} = {lt, 16'(nw), ad};
    req_valid_i = 1'b1;
    while (req_ready_o !== 1'b1) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    req_valid_i = 1'b0;
    g = 0;
    while (busy_o !== 1'b0 && g < 4000) begin
      @(negedge clk_sys_i);
      g++;
    end
  endtask
  always @(negedge clk_sys_i) begin
    wr_data_i <= wbuf[wi];
    wr_mask_i <= mbuf[wi];
  end
  always @(posedge clk_sys_i) if (wr_take_o === 1'b1) wi <= wi + 1;
  always @(posedge link_clock_true_o) rises = rises + 1;
  always @(negedge link_cs_n_o) rises = 0;
  always @(posedge link_cs_n_o) begin
    if (rise_q.size() > 0) begin
      check(32'(rises), 32'(rise_q.pop_front()));
      check({31'h0, link_clock_true_o}, 32'h0);
      check({31'h0, link_clock_comp_o}, 32'h1);
    end
  end
  always @(negedge clk_sys_i) begin
    if (rd_valid_o === 1'b1) begin
      if (rd_q.size() == 0) check(32'h1, 32'h0);
      else check({16'h0, rd_data_o}, rd_q.pop_front());
    end
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("BAD %0t run took too long", $time);
      tally_and_finish();
    end
  end
  initial begin
    int a, n;
    foreach (shadow[i]) shadow[i] = 16'h0000;
    foreach (wbuf[i]) {wbuf[i], mbuf[i]} = 18'h00000;
    {reset_n_i, req_valid_i, req_has_addr_i, req_write_i} = 4'h0;
    {req_latency_i, refresh, wr_data_i, wr_mask_i} = 20'h00000;
    {req_opcode_i, req_addr_i, req_words_i} = 56'h0;
    repeat (8) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    run(8'h5a, 1'b0, 1'b0, 1'b0, 0, 32'h0);
    run(8'h5a, 1'b1, 1'b0, 1'b0, 0, $random(seed));
    run(RW_OP, 1'b1, 1'b1, 1'b0, 1, $random(seed));
    check({16'h0, dev.cfg_q}, {16'h0, wbuf[0]});
    for (int j = 0; j < 8; j++) begin
      a = $random(seed);
      n = 1 + $unsigned($random(seed)) % 4;
      run(WR_OP, 1'b1, 1'b1, 1'b1, n, a);
      run(RD_OP, 1'b1, 1'b0, 1'b1, n + 1, a);
      if (j == 3) begin
        reset_n_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        check({31'h0, link_reset_n_o}, 32'h0);
        check({31'h0, link_dq_oe_o | strobe_mask_line_oe_o}, 32'h0);
        reset_n_i = 1'b1;
      end
    end
    check(32'(rd_q.size()), 32'h0);
    check({31'h0, dev.cmd_bad}, 32'h0);
    tally_and_finish();
  end
endmodule
